// ===== shared/coprocessor_irq_arbiter_defines.svh
// ---------------------------------------------------------------
// constants of the coprocessor request arbiter
// ---------------------------------------------------------------
// holds register offset, field positions and reset value as macros
// assumes inclusion by bare name from the design
`ifndef COPROCESSOR_IRQ_ARBITER_DEFINES_SVH
`define COPROCESSOR_IRQ_ARBITER_DEFINES_SVH

// byte offset of the control register
`define CTRL_OFFSET        12'h000
// field positions
`define CUR_PRIO_LSB       0
`define CUR_PRIO_MSB       7
`define ENABLE_BIT         8
`define PEND_PRIO_LSB      16
`define PEND_PRIO_MSB      23
`define ROUND_CNT_LSB      24
`define ROUND_CNT_MSB      25
`define SINGLE_CLK_BIT     26
// reset value of the whole register
`define CTRL_RESET         32'h0000_0000
// neutral value of an 8-bit priority
`define PRIO_NONE          8'h00
// full priority mask for four rounds
`define PRIO_FULL_MASK     8'hFF

`endif

// ===== shared/coprocessor_irq_arbiter_pkg.sv
// ---------------------------------------------------------------
// types of the coprocessor request arbiter
// ---------------------------------------------------------------
// holds the register image layout and the arbiter states
`default_nettype none
package coprocessor_irq_arbiter_pkg;
	// register image in bit order, reserved fields read as zero
	typedef struct packed {
		logic [4:0] reserved_hi;
		logic       single_clock_round_select;
		logic [1:0] arbitration_round_count;
		logic [7:0] pending_request_priority;
		logic [6:0] reserved_lo;
		logic       global_request_enable;
		logic [7:0] current_coprocessor_priority;
	} control_reg_type;

	// arbiter sequence
	typedef enum logic [1:0] {
		ARB_IDLE,
		ARB_RUN,
		ARB_PENDING
	} arb_state_type;
endpackage
`default_nettype wire

// ===== hw/coprocessor_irq_arbiter.sv
// ---------------------------------------------------------------
// coprocessor request arbiter with its control register
// ---------------------------------------------------------------
// single AHB-Lite slave, one clock, request nodes on the same clock
// the core drops its busy flag when a channel program ends
//
// The AHB-Lite interface to the registers and the placing of the registers were chosen for this implementation.
`include "coprocessor_irq_arbiter_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module coprocessor_irq_arbiter
	import coprocessor_irq_arbiter_pkg::*;
#(
	parameter int NODES      = 8,  // number of request nodes
	parameter int ADDR_WIDTH = 12  // decoded address bits
) (
	input  wire logic                  hclk,                // system clock
	input  wire logic                  hresetn,             // async reset, low
	input  wire logic                  clk_en,              // freezes all state when low
	input  wire logic                  hsel,                // slave select
	input  wire logic [ADDR_WIDTH-1:0] haddr,               // byte address
	input  wire logic [1:0]            htrans,              // transfer type
	input  wire logic                  hwrite,              // write transfer
	input  wire logic [2:0]            hsize,               // transfer size
	input  wire logic [31:0]           hwdata,              // write data
	input  wire logic                  hready,              // bus ready in
	output logic                       hreadyout,           // slave ready
	output logic                       hresp,               // always okay
	output logic [31:0]                hrdata,              // read data
	input  wire logic [NODES-1:0]      node_request,        // node request levels
	input  wire logic [NODES*8-1:0]    node_priority,       // priorities, node 0 low
	output logic [NODES-1:0]           node_ack,            // one-cycle acknowledge
	input  wire logic                  core_enable_flag,    // core enable flag level
	input  wire logic                  core_busy,           // core servicing a request
	input  wire logic                  core_entry,          // channel program entered
	input  wire logic                  core_exit,           // channel program exited
	input  wire logic [7:0]            core_load_priority,  // priority loaded on entry/exit
	input  wire logic                  core_ack,            // core takes the offer
	output logic                       core_request,        // offer to the core
	output logic [7:0]                 core_request_priority // priority offered
);

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	control_reg_type            ctrl;
	arb_state_type              state;
	logic [NODES-1:0]           cand;
	logic [NODES-1:0]           valid_prev;
	logic [1:0]                 pair_idx;
	logic                       phase;
	logic [$clog2(NODES)-1:0]   winner;
	logic                       wr_pend;
	logic [ADDR_WIDTH-1:0]      wr_addr;
	logic [7:0]                 pending_prio;
	logic [7:0]                 current_prio;
	logic                       enable_copy;
	logic [1:0]                 round_count;
	logic                       one_clock_round;

	// ---------------------------------------------------------------
	// request decode
	// ---------------------------------------------------------------
	logic [7:0]       prio_mask;
	logic [NODES-1:0] valid;
	logic [NODES-1:0] new_req;
	logic [NODES-1:0] keep;
	logic [7:0]       slices [NODES];
	logic [1:0]       slice_max;
	logic [7:0]       win_prio;
	logic             last_step;
	logic             offer;
	logic             take;
	logic             restart;
	logic [NODES-1:0] winner_onehot;
	logic [NODES-1:0] live;
	logic [NODES-1:0] next_cand;

	// mask of examined bits by round count
	assign prio_mask = `PRIO_FULL_MASK >> {ctrl.arbitration_round_count, 1'b0};

	// per-node validity and current slice
	genvar g;
	generate
		for (g = 0; g < NODES; g++) begin : g_node
			assign valid[g]  = node_request[g] &&
				((node_priority[g*8 +: 8] & prio_mask) != `PRIO_NONE);
			assign slices[g] = node_priority[g*8 +: 8] & prio_mask;
			assign keep[g]   = cand[g] &&
				(slices[g][{pair_idx, 1'b0} +: 2] == slice_max);
			assign winner_onehot[g] = (winner == ($clog2(NODES))'(g));
		end
	endgenerate

	assign new_req = valid & ~valid_prev;

	// a node acked last edge still shows its request for one cycle; keep it out
	assign live      = valid & ~node_ack;
	assign next_cand = take ? (live & ~winner_onehot) : live;

	// largest 2-bit slice among remaining candidates
	always_comb begin
		slice_max = 2'h0;
		for (int i = 0; i < NODES; i++) begin
			if (cand[i] && slices[i][{pair_idx, 1'b0} +: 2] > slice_max) begin
				slice_max = slices[i][{pair_idx, 1'b0} +: 2];
			end
		end
	end

	// lowest-numbered survivor of the last round wins ties
	logic [$clog2(NODES)-1:0] next_winner;
	logic                     next_found;
	always_comb begin
		next_winner = '0;
		next_found  = 1'b0;
		for (int i = NODES - 1; i >= 0; i--) begin
			if (keep[i]) begin
				next_winner = i[$clog2(NODES)-1:0];
				next_found  = 1'b1;
			end
		end
	end
	assign win_prio = slices[next_winner];

	// end of the last round: pair zero, final clock of the round
	assign last_step = (state == ARB_RUN) && (pair_idx == 2'h0) &&
		(phase || ctrl.single_clock_round_select);

	// offer to the core and its acceptance
	assign offer = (state == ARB_PENDING) && !core_busy && ctrl.global_request_enable &&
		(ctrl.pending_request_priority > ctrl.current_coprocessor_priority);
	assign take    = offer && core_ack;
	assign restart = (|new_req) || take;

	assign core_request          = offer;
	assign core_request_priority = ctrl.pending_request_priority;

	// ---------------------------------------------------------------
	// arbitration sequence
	// ---------------------------------------------------------------
	// request history for new-request detection
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			valid_prev <= '0;
		end else if (clk_en) begin
			valid_prev <= valid;
		end
	end

	// state, candidates, round pointer and clock phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state    <= ARB_IDLE;
			cand     <= '0;
			pair_idx <= 2'h0;
			phase    <= 1'b0;
		end else if (clk_en) begin
			if (restart || (state == ARB_IDLE && |live)) begin
				// an acked node is left out while it drops its request
				cand     <= next_cand;
				pair_idx <= 2'h3 - ctrl.arbitration_round_count;
				phase    <= 1'b0;
				state    <= (next_cand != '0) ? ARB_RUN : ARB_IDLE;
			end else if (state == ARB_RUN) begin
				if (phase || ctrl.single_clock_round_select) begin
					cand     <= keep;
					phase    <= 1'b0;
					pair_idx <= pair_idx - 2'h1;
					if (pair_idx == 2'h0) begin
						state <= next_found ? ARB_PENDING : ARB_IDLE;
					end
				end else begin
					phase <= 1'b1;
				end
			end else if (state == ARB_PENDING && !valid[winner]) begin
				state <= ARB_IDLE; // winner withdrew its request
			end
		end
	end

	// remembered winner
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			winner <= '0;
		end else if (clk_en && last_step && !restart) begin
			winner <= next_winner;
		end
	end

	// acknowledge back to the winning node
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			node_ack <= '0;
		end else if (clk_en) begin
			node_ack <= take ? winner_onehot : '0;
		end
	end

	// ---------------------------------------------------------------
	// control register
	// ---------------------------------------------------------------
	logic sw_write;
	assign sw_write = wr_pend && (wr_addr == `CTRL_OFFSET);

	// pending priority: cleared on restart, loaded at the end, hardware only
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pending_prio <= `PRIO_NONE;
		end else if (clk_en) begin
			if (restart) begin
				pending_prio <= `PRIO_NONE;
			end else if (last_step) begin
				pending_prio <= next_found ? win_prio : `PRIO_NONE;
			end else if (state == ARB_PENDING && !valid[winner]) begin
				pending_prio <= `PRIO_NONE;
			end
		end
	end

	// current priority: hardware load wins over software write
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			current_prio <= `PRIO_NONE;
		end else if (clk_en) begin
			if (core_entry || core_exit) begin
				current_prio <= core_load_priority;
			end else if (sw_write) begin
				current_prio <= hwdata[`CUR_PRIO_MSB:`CUR_PRIO_LSB];
			end
		end
	end

	// global enable mirrors the core flag
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			enable_copy <= 1'b0;
		end else if (clk_en) begin
			enable_copy <= core_enable_flag;
		end
	end

	// software-only arbitration controls
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			round_count     <= 2'h0;
			one_clock_round <= 1'b0;
		end else if (clk_en && sw_write) begin
			round_count     <= hwdata[`ROUND_CNT_MSB:`ROUND_CNT_LSB];
			one_clock_round <= hwdata[`SINGLE_CLK_BIT];
		end
	end

	// register image from the field flops, reserved fields constant zero
	assign ctrl = {5'h00, one_clock_round, round_count, pending_prio, 7'h00, enable_copy,
		current_prio};

	// ---------------------------------------------------------------
	// AHB-Lite slave
	// ---------------------------------------------------------------
	logic addr_phase;
	assign addr_phase = hsel && hready && htrans[1];
	assign hreadyout  = 1'b1;
	assign hresp      = 1'b0;

	// write address phase held for the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			wr_addr <= '0;
		end else if (clk_en) begin
			wr_pend <= addr_phase && hwrite;
			wr_addr <= haddr;
		end
	end

	// read data captured at the address phase; unmapped reads zero
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (clk_en && addr_phase && !hwrite) begin
			if (haddr == `CTRL_OFFSET) begin
				hrdata <= ctrl;
			end else begin
				hrdata <= 32'h0000_0000;
			end
		end
	end

endmodule // coprocessor_irq_arbiter

`default_nettype wire

// ===== verif/coprocessor_irq_arbiter_assertions.sv
// ------------------------------------------------------------
// checker for the coprocessor request arbiter
// ------------------------------------------------------------
// sees only the top module ports, attached by the bind below
`timescale 1ns/1ps
`default_nettype none
module arb_checker #(
	parameter int NODES = 8  // number of request nodes
) (
	input wire logic               hclk,                 // system clock
	input wire logic               hresetn,              // reset, low
	input wire logic [31:0]        hrdata,               // read data
	input wire logic [NODES-1:0]   node_request,         // node requests
	input wire logic [NODES*8-1:0] node_priority,        // node priorities
	input wire logic [NODES-1:0]   node_ack,             // node acknowledge
	input wire logic               core_enable_flag,     // core enable flag
	input wire logic               core_busy,            // core servicing
	input wire logic               core_ack,             // core takes offer
	input wire logic               core_request,         // offer to core
	input wire logic [7:0]         core_request_priority // offered priority
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// offer taken by the core
	sequence s_taken;
		core_request && core_ack;
	endsequence
	// node five posts a request valid under every round count
	sequence s_new_request;
		$rose(node_request[5]) && node_priority[41:40] != 2'h0;
	endsequence
	a_busy_blocks: assert property (core_busy |-> !core_request)
		else $error("offer while core busy");
	a_offer_nonzero: assert property (core_request |-> core_request_priority != 8'h00)
		else $error("offer with zero priority");
	a_ack_winner: assert property (s_taken |=> $onehot(node_ack) && core_request_priority == 8'h00)
		else $error("acknowledge not passed on");
	a_no_stray_ack: assert property (!(core_request && core_ack) |=> node_ack == '0)
		else $error("node acknowledge without taken offer");
	a_enable_gate: assert property (!core_enable_flag [*2] |-> !core_request)
		else $error("offer while disabled");
	a_restart_clear: assert property (s_new_request |=> core_request_priority == 8'h00)
		else $error("pending not cleared on new request");
	a_pending_hold: assert property (core_request && !core_ack |=>
		$stable(core_request_priority) || core_request_priority == 8'h00)
		else $error("pending changed without restart");
	a_reserved_zero: assert property (hrdata[15:9] == 7'h00 && hrdata[31:27] == 5'h00)
		else $error("reserved bits read nonzero");
endmodule // arb_checker

bind coprocessor_irq_arbiter arb_checker #(.NODES(NODES)) chk (
	.hclk(hclk), .hresetn(hresetn), .hrdata(hrdata), .node_request(node_request),
	.node_priority(node_priority), .node_ack(node_ack), .core_enable_flag(core_enable_flag),
	.core_busy(core_busy), .core_ack(core_ack), .core_request(core_request),
	.core_request_priority(core_request_priority));
`default_nettype wire

// ===== verif/arb_partner_model.sv
// ------------------------------------------------------------
// request nodes and a non-nesting coprocessor core
// ------------------------------------------------------------
// bench posts requests through raise and lets offers be taken through take
`timescale 1ns/1ps
`default_nettype none
module arb_partner_model (
	input  wire logic       hclk,                  // system clock
	input  wire logic       hresetn,               // reset, low
	input  wire logic [7:0] node_ack,              // acknowledge per node
	input  wire logic       core_request,          // offer from arbiter
	input  wire logic [7:0] core_request_priority, // offered priority
	output logic [7:0]      node_request,          // request levels
	output logic            core_ack,              // offer taken
	output logic            core_busy,             // servicing
	output logic            core_entry,            // channel entry pulse
	output logic            core_exit,             // channel exit pulse
	output logic [7:0]      core_load_priority     // priority to load
);
	logic [7:0] raise = 8'h00; // requests posted by the bench
	logic       take  = 1'b0;  // core accepts offers
	int         left;          // service cycles remaining
	// a node holds its request until acknowledged
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			node_request <= 8'h00;
		else
			node_request <= (node_request | raise) & ~node_ack;
	end
	// core takes one offer at a time, serves it, then exits at priority zero
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			core_ack <= 1'b0;
			core_busy <= 1'b0;
			core_entry <= 1'b0;
			core_exit <= 1'b0;
			core_load_priority <= 8'h00;
			left <= 0;
		end else begin
			core_ack <= take && core_request && !core_ack && !core_busy;
			core_entry <= core_ack;
			core_exit <= left == 1;
			core_load_priority <= core_ack ? core_request_priority : 8'h00;
			if (core_ack) begin
				core_busy <= 1'b1;
				left <= 12;
			end else if (left > 0) begin
				left <= left - 1;
				core_busy <= left != 1;
			end
		end
	end
endmodule // arb_partner_model
`default_nettype wire

// ===== verif/testbench.sv
// ------------------------------------------------------------
// self-checking bench of the coprocessor request arbiter
// ------------------------------------------------------------
// one AHB-Lite master, partner model on the node and core side
`timescale 1ns/1ps
`default_nettype none
`define CHECK(got, exp) begin n_tests++; if ((got) !== (exp)) begin error_cnt++; \
	$display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module testbench;
	logic        hclk, hresetn, clk_en, hsel, hwrite, hreadyout, hresp;
	logic [11:0] haddr;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [31:0] hwdata, hrdata, q;
	logic [7:0]  node_request, node_ack, core_load_priority, core_request_priority, m, w;
	logic [63:0] node_priority;
	logic        core_enable_flag, core_busy, core_entry, core_exit, core_ack, core_request;
	logic [7:0]  cur [3] = '{8'hFF, 8'h35, 8'h34};
	int          error_cnt, n_tests, lat;
	coprocessor_irq_arbiter DUT (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.node_request(node_request), .node_priority(node_priority), .node_ack(node_ack),
		.core_enable_flag(core_enable_flag), .core_busy(core_busy), .core_entry(core_entry),
		.core_exit(core_exit), .core_load_priority(core_load_priority), .core_ack(core_ack),
		.core_request(core_request), .core_request_priority(core_request_priority));
	arb_partner_model P (.hclk(hclk), .hresetn(hresetn), .node_ack(node_ack),
		.core_request(core_request), .core_request_priority(core_request_priority),
		.node_request(node_request), .core_ack(core_ack), .core_busy(core_busy),
		.core_entry(core_entry), .core_exit(core_exit), .core_load_priority(core_load_priority));
	// 20 MHz system clock
	always #25 hclk = ~hclk;
	// one single transfer, address phase then data phase
	task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= wr;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask
	// read and compare
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0000_0000);
		`CHECK(q, e)
		`CHECK(hresp, 1'b0)
	endtask
	// post requests, count edges until the offer, compare its priority
	task automatic offer(input logic [7:0] r, input logic [7:0] p, input int l);
		int n;
		@(posedge hclk);
		P.raise <= r;
		@(posedge hclk);
		P.raise <= 8'h00;
		n = 0;
		// a standing offer must first drop at the restart edge
		do begin
			@(negedge hclk);
			n++;
		end while ((n < 2 || core_request !== 1'b1) && n < 40);
		`CHECK(n, l)
		`CHECK(core_request_priority, p)
	endtask
	// let the core take every offer until all nodes are served
	task automatic drain();
		int n;
		n = 0;
		@(posedge hclk);
		P.take <= 1'b1;
		do begin
			@(negedge hclk);
			n++;
		end while ((node_request !== 8'h00 || core_busy !== 1'b0) && n < 200);
		@(posedge hclk);
		P.take <= 1'b0;
	endtask
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// watchdog against a hang
	initial begin
		repeat (20000) @(posedge hclk);
		error_cnt++;
		complete_run();
	end
	// main sequence
	initial begin
		hclk = 1'b0;
		hresetn = 1'b0;
		clk_en = 1'b1;
		{hsel, hwrite, htrans, haddr, hwdata} = '0;
		hsize = 3'h2;
		node_priority = 64'h0000_3500_00C6_0000;
		core_enable_flag = 1'b0;
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		rd(12'h000, 32'h0000_0000);
		rd(12'h004, 32'h0000_0000);
		bus(1'b1, 12'h000, 32'h07FF_01FF);
		rd(12'h000, 32'h0700_00FF);
		bus(1'b1, 12'h000, 32'h0000_0000);
		offer(8'h20, 8'h35, 40);
		rd(12'h000, 32'h0035_0000);
		core_enable_flag <= 1'b1;
		for (int i = 0; i < 3; i++) begin
			bus(1'b1, 12'h000, {24'h0, cur[i]});
			repeat (2) @(negedge hclk);
			`CHECK(core_request, i == 2)
		end
		rd(12'h000, 32'h0035_0134);
		drain();
		for (int k = 0; k < 8; k++) begin
			m = 8'hFF >> (2 * k[1:0]);
			lat = (4 - k[1:0]) * (k[2] ? 1 : 2) + 2;
			w = ((8'hC6 & m) > (8'h35 & m)) ? (8'hC6 & m) : (8'h35 & m);
			bus(1'b1, 12'h000, 32'(k) << 24);
			rd(12'h000, (32'(k) << 24) | 32'h100);
			offer(8'h20, 8'h35 & m, lat);
			offer(8'h04, w, lat);
			rd(12'h000, (32'(k) << 24) | 32'h100 | {8'h0, w, 16'h0});
			drain();
			rd(12'h000, (32'(k) << 24) | 32'h100);
		end
		complete_run();
	end
endmodule // testbench
`default_nettype wire
